// *** test/modbus_serial_port_setup_tb.sv ***
// self-checking bench for the serial port setup block
`timescale 1ns/1ns
`default_nettype none
module modbus_serial_port_setup_tb;
  import msps_pkg::*;
  // short millisecond, slow clock figure gives 200 cycles a bit at 9600
  localparam int MSC = 20;
  localparam int FHZ = 1_920_000;
  logic        clk, rst, sel, we, ack, rxd, cts, txd, rts;
  logic        tx_valid, tx_last, tx_ready, rx_valid, rx_perr, rx_ferr;
  logic        req_valid, f_valid, f_hit, active, ascii;
  logic [15:0] addr, wdata, rdata, req_reg, f_index;
  logic [7:0]  tx_data, rx_data, req_func;
  logic [2:0]  role;
  logic [11:0] v;
  time         t0, t1, t2, tv;
  int          error_cnt = 0;
  int          checks = 0;

  msps_port #(.CLK_FREQ_HZ(FHZ), .MS_CYCLES(MSC)) dut_u (
    .CLK_SYS(clk), .RST(rst), .CFG_SEL(sel), .CFG_WE(we), .CFG_ADDR(addr),
    .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_ACK(ack), .RXD(rxd), .CTS(cts),
    .TXD(txd), .RTS(rts), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .TX_READY(tx_ready), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_PERR(rx_perr), .RX_FERR(rx_ferr),
    .REQ_VALID(req_valid), .REQ_FUNC(req_func), .REQ_REG(req_reg),
    .FLOAT_VALID(f_valid), .FLOAT_HIT(f_hit), .FLOAT_INDEX(f_index),
    .PORT_ACTIVE(active), .ROLE_CODE(role), .ASCII_MODE(ascii));

  msps_remote remote_u (.clk(clk), .txd(txd), .rxd(rxd), .cts(cts));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_rng(input longint got, input longint lo, input longint hi);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask : check_rng

  task automatic cfg_acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                         output logic [15:0] r);
    @(negedge clk);
    sel = 1'b1;
    we = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    r = rdata;
    check_val(ack, 1);
    sel = 1'b0;
    @(negedge clk);
  endtask : cfg_acc

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] r;
    cfg_acc(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] r;
    cfg_acc(1'b0, a, 16'h0000, r);
    check_val(r, e);
  endtask : rd_chk

  // holds the character until the block takes it
  task automatic send(input logic [7:0] d, input logic last, output time t);
    int n;
    n = 0;
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = d;
    tx_last = last;
    t = $time;
    do begin
      @(negedge clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 20000);
    check_val(tx_ready, 1);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask : send

  task automatic req_chk(input logic [7:0] f, input logic [15:0] r, input logic h,
                         input logic [15:0] x);
    @(negedge clk);
    req_valid = 1'b1;
    req_func = f;
    req_reg = r;
    @(negedge clk);
    check_val(f_valid, 1);
    req_valid = 1'b0;
    @(negedge clk);
    check_val(f_hit, h);
    check_val(f_index, x);
  endtask : req_chk

  task automatic wait_rx;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rx_valid !== 1'b1 && n < 2000);
    check_val(rx_valid, 1);
  endtask : wait_rx

  task automatic t_regs;
    for (int i = 0; i < NREG; i++) rd_chk(A_ENABLE + 16'(i), RST_VAL[i]);
    wr(16'h13A0, 16'h1234);
    rd_chk(16'h13A0, 16'h0000);
    wr(A_LEAD, 16'hFFFF);
    rd_chk(A_LEAD, 16'hFFFF);
    $display("test regs done");
  endtask : t_regs

  task automatic t_mode;
    int n;
    for (int i = 0; i < 5; i++) begin
      wr(A_ROLE, 16'(i));
      check_val(role, i);
    end
    wr(A_PROTO, 16'h0001);
    check_val(ascii, 1);
    wr(A_PROTO, 16'h0000);
    check_val(ascii, 0);
    wr(A_LEAD, 16'h0000);
    tx_valid = 1'b1;
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (rts !== 1'b0 || tx_ready !== 1'b0 || active !== 1'b0) n++;
    end
    tx_valid = 1'b0;
    check_val(n, 0);
    wr(A_ENABLE, 16'h0001);
    check_val(active, 1);
    $display("test mode done");
  endtask : t_mode

  task automatic t_float;
    wr(A_RSW, 16'h0001);
    wr(A_RFIRST, 16'd100);
    wr(A_RBASE, 16'd500);
    req_chk(8'h03, 16'd105, 1'b1, 16'd505);
    req_chk(8'h06, 16'd100, 1'b1, 16'd500);
    req_chk(8'h10, 16'd200, 1'b1, 16'd600);
    req_chk(8'h04, 16'd105, 1'b0, 16'd0);
    req_chk(8'h03, 16'd99, 1'b0, 16'd0);
    wr(A_RSW, 16'h0000);
    req_chk(8'h03, 16'd105, 1'b0, 16'd0);
    $display("test float done");
  endtask : t_float

  // master at 9600, even parity, two stops, lead 2 ms, trail 3 ms
  task automatic t_master;
    wr(A_ROLE, 16'h0000);
    wr(A_PARITY, 16'h0002);
    wr(A_STOP, 16'h0002);
    wr(A_LEAD, 16'h0002);
    wr(A_TRAIL, 16'h0003);
    fork
      send(8'hA5, 1'b1, tv);
      begin
        @(posedge rts);
        t0 = $time;
        remote_u.get_char(11, 200, v, t1);
        @(negedge rts);
        t2 = $time;
      end
    join
    check_val(v, {1'b0, 2'b11, ^8'hA5, 8'hA5});
    check_rng(longint'((t1 - t0) / 50), 40, 48);
    check_rng(longint'((t2 - t1) / 50), 2460, 2700);
    $display("test master done");
  endtask : t_master

  // slave: hold-off 2 ms comes before the 1 ms lead-in
  task automatic t_slave;
    wr(A_ROLE, 16'h0001);
    wr(A_PARITY, 16'h0000);
    wr(A_STOP, 16'h0001);
    wr(A_HOLD, 16'h0002);
    wr(A_LEAD, 16'h0001);
    wr(A_TRAIL, 16'h0000);
    fork
      send(8'h3C, 1'b1, tv);
      begin
        @(posedge rts);
        t0 = $time;
        remote_u.get_char(9, 200, v, t1);
        @(negedge rts);
      end
    join
    check_val(v, {4'h0, 1'b1, 8'h3C});
    check_rng(longint'((t0 - tv) / 50), 40, 48);
    check_rng(longint'((t1 - t0) / 50), 20, 28);
    $display("test slave done");
  endtask : t_slave

  // gated on CTS at 19200, five bits, odd parity
  task automatic t_cts;
    int n;
    wr(A_ROLE, 16'h0000);
    wr(A_HOLD, 16'h0000);
    wr(A_LEAD, 16'h0000);
    wr(A_CTS, 16'h0001);
    wr(A_WIDTH, 16'h0005);
    wr(A_PARITY, 16'h0001);
    wr(A_BAUD, 16'h4B00);
    remote_u.set_cts(1'b0);
    tx_valid = 1'b1;
    tx_data = 8'h13;
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (tx_ready !== 1'b0) n++;
    end
    check_val(n, 0);
    remote_u.set_cts(1'b1);
    fork
      send(8'h13, 1'b1, tv);
      remote_u.get_char(7, 100, v, t1);
    join
    check_val(v, {5'h00, 1'b1, ~^5'h13, 5'h13});
    $display("test cts done");
  endtask : t_cts

  // receive at the abbreviated 38400 code, seven bits, odd parity
  task automatic t_rx;
    wr(A_WIDTH, 16'h0007);
    wr(A_BAUD, B_384);
    for (int b = 0; b < 2; b++) begin
      fork
        remote_u.send_char(8'h5A, 7, 1, b[0], 50);
        wait_rx();
      join
      check_val(rx_data, 8'h5A);
      check_val(rx_perr, b);
      check_val(rx_ferr, 0);
    end
    $display("test rx done");
  endtask : t_rx

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rst = 1'b1;
    {sel, we, tx_valid, tx_last, req_valid} = '0;
    {addr, wdata, req_reg, tx_data, req_func} = '0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_mode();
    t_float();
    t_master();
    t_slave();
    t_cts();
    t_rx();
    give_verdict();
  end

  // the tests need about 7000 cycles; a hang past 80000 cycles ends the run
  initial begin
    #(80000 * 50);
    error_cnt++;
    give_verdict();
  end
endmodule : modbus_serial_port_setup_tb
`default_nettype wire

// *** test/msps_remote.sv ***
// remote serial party: drives the receive line and CTS, decodes the transmit line
`timescale 1ns/1ns
`default_nettype none
module msps_remote (
  // clock
  input  wire logic clk,
  // serial pins
  input  wire logic txd,
  output logic      rxd,
  output logic      cts
);
  // receive line rests at its pull-up level between characters
  initial begin
    rxd = 1'b1;
    cts = 1'b0;
  end

  task automatic set_cts(input logic v);
    @(negedge clk);
    cts = v;
  endtask : set_cts

  // bad flips the parity bit, only when a test asks for it
  task automatic send_char(input logic [7:0] d, input int w, input int par,
                           input logic bad, input int bc);
    logic p;
    p = 1'b0;
    for (int i = 0; i < w; i++) p ^= d[i];
    @(negedge clk);
    rxd = 1'b0;
    repeat (bc) @(negedge clk);
    for (int i = 0; i < w; i++) begin
      rxd = d[i];
      repeat (bc) @(negedge clk);
    end
    if (par != 0) begin
      rxd = ((par == 1) ? ~p : p) ^ bad;
      repeat (bc) @(negedge clk);
    end
    rxd = 1'b1;
    repeat (bc) @(negedge clk);
  endtask : send_char

  // n bits after the start bit, sampled mid-bit on the quiet edge
  task automatic get_char(input int n, input int bc, output logic [11:0] v,
                          output time ts);
    v = '0;
    @(negedge txd);
    ts = $time;
    repeat (bc / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (bc) @(negedge clk);
      v[i] = txd;
    end
  endtask : get_char
endmodule : msps_remote
`default_nettype wire

// *** verilog/msps_pkg.sv ***
// package: constants, types and register map of the serial port setup block
package msps_pkg;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  localparam int MS_NS  = 1_000_000;
  localparam int MS_CYC = MS_NS / CLK_NS;

  // register offsets (word addresses on the configuration port)
  localparam logic [15:0] A_ENABLE = 16'h1392;
  localparam logic [15:0] A_ROLE   = 16'h1393;
  localparam logic [15:0] A_RSW    = 16'h1394;
  localparam logic [15:0] A_RFIRST = 16'h1395;
  localparam logic [15:0] A_RBASE  = 16'h1396;
  localparam logic [15:0] A_PROTO  = 16'h1397;
  localparam logic [15:0] A_BAUD   = 16'h1398;
  localparam logic [15:0] A_PARITY = 16'h1399;
  localparam logic [15:0] A_WIDTH  = 16'h139A;
  localparam logic [15:0] A_STOP   = 16'h139B;
  localparam logic [15:0] A_LEAD   = 16'h139C;
  localparam logic [15:0] A_TRAIL  = 16'h139D;
  localparam logic [15:0] A_HOLD   = 16'h139E;
  localparam logic [15:0] A_CTS    = 16'h139F;
  localparam logic [15:0] A_STATUS = 16'h1B00;
  localparam int          NREG     = 14;

  // register indices relative to A_ENABLE
  localparam int I_ENABLE = 0;
  localparam int I_ROLE   = 1;
  localparam int I_RSW    = 2;
  localparam int I_RFIRST = 3;
  localparam int I_RBASE  = 4;
  localparam int I_PROTO  = 5;
  localparam int I_BAUD   = 6;
  localparam int I_PARITY = 7;
  localparam int I_WIDTH  = 8;
  localparam int I_STOP   = 9;
  localparam int I_LEAD   = 10;
  localparam int I_TRAIL  = 11;
  localparam int I_HOLD   = 12;
  localparam int I_CTS    = 13;

  // reset values, in index order
  localparam logic [15:0] RST_VAL [NREG] = '{
    16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h2580,
    16'h0000, 16'h0008, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // setting codes
  localparam logic [15:0] ON         = 16'h0001;
  localparam logic [2:0]  ROLE_MASTR = 3'h0;
  localparam logic [15:0] PAR_ODD    = 16'h0001;
  localparam logic [15:0] PAR_EVEN   = 16'h0002;
  localparam logic [15:0] STOP_TWO   = 16'h0002;
  localparam logic [15:0] WID_MIN    = 16'h0005;
  localparam logic [15:0] WID_MAX    = 16'h0008;
  localparam logic [3:0]  WID_DFLT   = 4'h8;
  localparam logic [7:0]  FC_RD      = 8'h03;
  localparam logic [7:0]  FC_WR1     = 8'h06;
  localparam logic [7:0]  FC_WRN     = 8'h10;

  // baud setting codes and the rates they select
  localparam logic [15:0] B_110 = 16'h006E;
  localparam logic [15:0] B_150 = 16'h0096;
  localparam logic [15:0] B_300 = 16'h012C;
  localparam logic [15:0] B_600 = 16'h0258;
  localparam logic [15:0] B_1K2 = 16'h04B0;
  localparam logic [15:0] B_2K4 = 16'h0960;
  localparam logic [15:0] B_4K8 = 16'h12C0;
  localparam logic [15:0] B_9K6 = 16'h2580;
  localparam logic [15:0] B_19K = 16'h4B00;
  localparam logic [15:0] B_28K = 16'h7080;
  localparam logic [15:0] B_384 = 16'h0180;
  localparam logic [15:0] B_576 = 16'h0240;
  localparam logic [15:0] B_115 = 16'h0073;
  localparam int          R_38K = 38400;
  localparam int          R_57K = 57600;
  localparam int          R_115 = 115200;

  // status word bit positions
  localparam int S_EN   = 0;
  localparam int S_BUSY = 1;
  localparam int S_CTS  = 2;
  localparam int S_RTS  = 3;
  localparam int S_ST   = 4;

  typedef struct packed {
    logic [3:0] width;
    logic       par_en;
    logic       par_odd;
    logic       two_stop;
  } msps_line_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_HOLD  = 3'h1,
    ST_LEAD  = 3'h3,
    ST_SEND  = 3'h2,
    ST_TRAIL = 3'h6
  } msps_state_t;
endpackage : msps_pkg

// *** verilog/msps_port.sv ***
// serial application port: setup registers, line timing, character engines
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE_01 - enable zero idles port, one runs it
// RULE_02 - role code selects master or slave kind
// RULE_03 - real switch maps codes 3,6,16 to floats
// RULE_04 - register at/above first index is float
// RULE_05 - float table base ignored when switch off
// RULE_06 - protocol 0 binary, 1 ASCII framing
// RULE_07 - literal baud rates, codes 384/576/115 abbreviate
// RULE_08 - parity none, odd or even
// RULE_09 - data width five to eight bits
// RULE_10 - one or two stop bits sent
// RULE_11 - lead-in delay after RTS before first character
// RULE_12 - trailing delay after last character, then RTS low
// RULE_13 - reply hold-off elapses before RTS lead-in
// RULE_14 - CTS gate: send only while CTS high
// RULE_15 - millisecond tick from system clock times delays
module msps_port
  import msps_pkg::*;
#(
  parameter int CLK_FREQ_HZ = msps_pkg::CLK_HZ,
  parameter int MS_CYCLES   = msps_pkg::MS_CYC
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // setup word port
  input  wire logic        CFG_SEL,
  input  wire logic        CFG_WE,
  input  wire logic [15:0] CFG_ADDR,
  input  wire logic [15:0] CFG_WDATA,
  output logic      [15:0] CFG_RDATA,
  output logic             CFG_ACK,
  // serial pins
  input  wire logic        RXD,
  input  wire logic        CTS,
  output logic             TXD,
  output logic             RTS,
  // characters to send
  input  wire logic        TX_VALID,
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_LAST,
  output logic             TX_READY,
  // characters received
  output logic             RX_VALID,
  output logic      [7:0]  RX_DATA,
  output logic             RX_PERR,
  output logic             RX_FERR,
  // request classification
  input  wire logic        REQ_VALID,
  input  wire logic [7:0]  REQ_FUNC,
  input  wire logic [15:0] REQ_REG,
  output logic             FLOAT_VALID,
  output logic             FLOAT_HIT,
  output logic      [15:0] FLOAT_INDEX,
  // port mode
  output logic             PORT_ACTIVE,
  output logic      [2:0]  ROLE_CODE,
  output logic             ASCII_MODE
);
  localparam int MS_W = 16;

  logic [15:0] regs_q [NREG];
  logic [15:0] idx;
  logic        hit;
  logic        en;
  logic        float_on;
  msps_line_t  line;
  logic [17:0] div_q;
  logic        rxd_s1, rxd_s2, cts_s1, cts_s2;
  logic        cts_ok;
  msps_state_t st_q, st_d;
  logic [15:0] cnt_q;
  logic        ld;
  logic [15:0] ld_val;
  logic [MS_W-1:0] ms_q;
  logic        tick;
  logic        take;
  logic        last_q;
  logic        tx_busy;
  logic        rx_line;

  assign idx      = CFG_ADDR - A_ENABLE;
  assign hit      = (CFG_ADDR >= A_ENABLE) && (CFG_ADDR <= A_CTS);
  assign en       = regs_q[I_ENABLE] == ON; // RULE_01
  assign float_on = regs_q[I_RSW] == ON;

  // setup words; a write outside the map is dropped
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NREG; i++) regs_q[i] <= RST_VAL[i];
    end else if (CFG_SEL && CFG_WE && hit) begin
      regs_q[idx[3:0]] <= CFG_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CFG_RDATA <= 16'h0000;
      CFG_ACK   <= 1'b0;
    end else begin
      CFG_ACK <= CFG_SEL;
      if (CFG_SEL && !CFG_WE) begin
        if (hit) CFG_RDATA <= regs_q[idx[3:0]];
        else if (CFG_ADDR == A_STATUS)
          CFG_RDATA <= {9'h000, st_q, RTS, cts_s2, tx_busy, en};
        else CFG_RDATA <= 16'h0000;
      end
    end
  end

  // character format decode; out-of-range settings fall back to 8-N-1
  always_comb begin
    line.width = WID_DFLT;
    if (regs_q[I_WIDTH] >= WID_MIN && regs_q[I_WIDTH] <= WID_MAX)
      line.width = regs_q[I_WIDTH][3:0]; // RULE_09
    line.par_en   = (regs_q[I_PARITY] == PAR_ODD) || (regs_q[I_PARITY] == PAR_EVEN); // RULE_08
    line.par_odd  = regs_q[I_PARITY] == PAR_ODD;
    line.two_stop = regs_q[I_STOP] == STOP_TWO; // RULE_10
  end

  // bit period in system clocks; unknown codes run at 9600
  function automatic logic [17:0] bit_div(input logic [15:0] code);
    int rate;
    case (code)
      B_110, B_150, B_300, B_600, B_1K2, B_2K4, B_4K8, B_9K6, B_19K, B_28K:
        rate = int'(code);
      B_384:   rate = R_38K;
      B_576:   rate = R_57K;
      B_115:   rate = R_115;
      default: rate = int'(B_9K6);
    endcase
    return 18'(CLK_FREQ_HZ / rate);
  endfunction : bit_div

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) div_q <= 18'h00000;
    else     div_q <= bit_div(regs_q[I_BAUD]); // RULE_07
  end

  // pins come from the far side of the cable
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      cts_s1 <= 1'b0;
      cts_s2 <= 1'b0;
    end else begin
      rxd_s1 <= RXD;
      rxd_s2 <= rxd_s1;
      cts_s1 <= CTS;
      cts_s2 <= cts_s1;
    end
  end

  assign cts_ok = (regs_q[I_CTS] != ON) || cts_s2; // RULE_14

  // millisecond prescaler, restarted with every delay load so a delay
  // of n lasts n full milliseconds rather than n-1 plus a fraction
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) ms_q <= '0;
    else if (ld || ms_q == MS_W'(MS_CYCLES - 1)) ms_q <= '0; // RULE_15
    else ms_q <= ms_q + 1'b1;
  end
  assign tick = !ld && (ms_q == MS_W'(MS_CYCLES - 1));

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) cnt_q <= 16'h0000;
    else if (ld) cnt_q <= ld_val;
    else if (tick && cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001; // RULE_15
  end

  assign take = (st_q == ST_SEND) && TX_VALID && TX_READY;

  // line sequence: hold-off, RTS lead-in, send, RTS trailing
  always_comb begin
    st_d   = st_q;
    ld     = 1'b0;
    ld_val = 16'h0000;
    case (st_q)
      ST_IDLE: begin
        if (en && TX_VALID) begin
          ld = 1'b1;
          if (regs_q[I_ROLE][2:0] == ROLE_MASTR) begin // RULE_02
            st_d   = ST_LEAD;
            ld_val = regs_q[I_LEAD];
          end else begin
            st_d   = ST_HOLD;
            ld_val = regs_q[I_HOLD]; // RULE_13
          end
        end
      end
      ST_HOLD: begin
        if (cnt_q == 16'h0000) begin
          st_d   = ST_LEAD; // RULE_13
          ld     = 1'b1;
          ld_val = regs_q[I_LEAD];
        end
      end
      ST_LEAD: begin
        if (cnt_q == 16'h0000) st_d = ST_SEND; // RULE_11
      end
      ST_SEND: begin
        if (last_q && !tx_busy) begin
          st_d   = ST_TRAIL;
          ld     = 1'b1;
          ld_val = regs_q[I_TRAIL]; // RULE_12
        end
      end
      ST_TRAIL: begin
        if (cnt_q == 16'h0000) st_d = ST_IDLE; // RULE_12
      end
      default: st_d = ST_IDLE;
    endcase
    if (!en) begin
      st_d = ST_IDLE; // RULE_01
      ld   = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) st_q <= ST_IDLE;
    else     st_q <= st_d;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) RTS <= 1'b0;
    else RTS <= (st_d == ST_LEAD) || (st_d == ST_SEND) || (st_d == ST_TRAIL); // RULE_11
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) last_q <= 1'b0;
    else if (st_q != ST_SEND) last_q <= 1'b0;
    else if (take && TX_LAST) last_q <= 1'b1;
  end

  // ready drops the cycle after a take so the engine sees one start
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) TX_READY <= 1'b0;
    else TX_READY <= (st_d == ST_SEND) && !tx_busy && !take && !last_q && cts_ok; // RULE_14
  end

  msps_tx u_tx (
    .clk   (CLK_SYS),
    .rst   (RST),
    .div   (div_q),
    .line  (line),
    .start (take),
    .data  (TX_DATA),
    .busy  (tx_busy),
    .txd   (TXD)
  );

  // a disabled port hears an idle line
  assign rx_line = en ? rxd_s2 : 1'b1; // RULE_01

  msps_rx u_rx (
    .clk   (CLK_SYS),
    .rst   (RST),
    .div   (div_q),
    .line  (line),
    .rxd   (rx_line),
    .valid (RX_VALID),
    .data  (RX_DATA),
    .perr  (RX_PERR),
    .ferr  (RX_FERR)
  );

  // floating-point region classification
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      FLOAT_VALID <= 1'b0;
      FLOAT_HIT   <= 1'b0;
      FLOAT_INDEX <= 16'h0000;
    end else begin
      FLOAT_VALID <= REQ_VALID;
      if (REQ_VALID) begin
        if (float_on && (REQ_FUNC == FC_RD || REQ_FUNC == FC_WR1 || REQ_FUNC == FC_WRN)
            && REQ_REG >= regs_q[I_RFIRST]) begin // RULE_03 RULE_04
          FLOAT_HIT   <= 1'b1;
          FLOAT_INDEX <= regs_q[I_RBASE] + (REQ_REG - regs_q[I_RFIRST]); // RULE_05
        end else begin
          FLOAT_HIT   <= 1'b0;
          FLOAT_INDEX <= 16'h0000; // RULE_05
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PORT_ACTIVE <= 1'b0;
      ROLE_CODE   <= 3'h0;
      ASCII_MODE  <= 1'b0;
    end else begin
      PORT_ACTIVE <= en; // RULE_01
      ROLE_CODE   <= regs_q[I_ROLE][2:0]; // RULE_02
      ASCII_MODE  <= regs_q[I_PROTO] == ON; // RULE_06
    end
  end

  // checks
  property p_off_idle;
    @(posedge CLK_SYS) disable iff (RST) !en |=> st_q == ST_IDLE ##1 !RTS;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("port off but not idle"); // RULE_01

  property p_master_lead;
    @(posedge CLK_SYS) disable iff (RST)
      st_q == ST_IDLE && en && TX_VALID && regs_q[I_ROLE][2:0] == ROLE_MASTR |=> st_q == ST_LEAD;
  endproperty
  a_master_lead: assert property (p_master_lead) else $error("master did not skip hold-off"); // RULE_02

  property p_float_hit;
    @(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && float_on && REQ_FUNC == FC_WRN && REQ_REG >= regs_q[I_RFIRST]
      |=> FLOAT_HIT && FLOAT_VALID;
  endproperty
  a_float_hit: assert property (p_float_hit) else $error("float request not flagged"); // RULE_04

  property p_float_off;
    @(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && !float_on |=> !FLOAT_HIT && FLOAT_INDEX == 16'h0000;
  endproperty
  a_float_off: assert property (p_float_off) else $error("float base used while off"); // RULE_05

  property p_baud_abbr;
    @(posedge CLK_SYS) disable iff (RST)
      regs_q[I_BAUD] == B_384 |=> div_q == 18'(CLK_FREQ_HZ / R_38K);
  endproperty
  a_baud_abbr: assert property (p_baud_abbr) else $error("short baud code misread"); // RULE_07

  sequence s_hold_end;
    st_q == ST_HOLD && cnt_q == 16'h0000 && en;
  endsequence
  property p_hold_then_lead;
    @(posedge CLK_SYS) disable iff (RST) s_hold_end |=> st_q == ST_LEAD && RTS;
  endproperty
  a_hold_then_lead: assert property (p_hold_then_lead) else $error("lead-in not after hold"); // RULE_13

  property p_lead_rts;
    @(posedge CLK_SYS) disable iff (RST) st_q == ST_LEAD |-> RTS && !tx_busy;
  endproperty
  a_lead_rts: assert property (p_lead_rts) else $error("sent before lead-in ended"); // RULE_11

  property p_rts_fall;
    @(posedge CLK_SYS) disable iff (RST) $fell(RTS) |-> $past(st_q) == ST_TRAIL || !$past(en);
  endproperty
  a_rts_fall: assert property (p_rts_fall) else $error("RTS dropped outside trailing"); // RULE_12

  property p_cts_gate;
    @(posedge CLK_SYS) disable iff (RST) take |-> regs_q[I_CTS] != ON || cts_s2;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("sent with CTS low"); // RULE_14

  property p_tick_gap;
    @(posedge CLK_SYS) disable iff (RST) tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ms ticks too close"); // RULE_15
endmodule : msps_port
`default_nettype wire

// *** verilog/msps_rx.sv ***
// character receiver: mid-bit sampling, parity and stop checking
`timescale 1ns/1ns
`default_nettype none
module msps_rx
  import msps_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // character format
  input  wire logic [17:0] div,
  input  wire msps_pkg::msps_line_t line,
  // synchronised line in
  input  wire logic        rxd,
  // character out
  output logic             valid,
  output logic [7:0]       data,
  output logic             perr,
  output logic             ferr
);
  logic        act_q;
  logic [3:0]  nbit_q;
  logic [17:0] bcnt_q;
  logic        acc_q;
  logic [3:0]  stop_at;

  assign stop_at = line.width + {3'h0, line.par_en} + 4'h1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_q  <= 1'b0;
      nbit_q <= 4'h0;
      bcnt_q <= 18'h00000;
      acc_q  <= 1'b0;
      valid  <= 1'b0;
      data   <= 8'h00;
      perr   <= 1'b0;
      ferr   <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (!act_q) begin
        if (!rxd) begin
          act_q  <= 1'b1;
          nbit_q <= 4'h0;
          bcnt_q <= div >> 1;
          acc_q  <= 1'b0;
          data   <= 8'h00;
        end
      end else if (bcnt_q != 18'h00000) begin
        bcnt_q <= bcnt_q - 18'h00001;
      end else begin
        bcnt_q <= div - 18'h00001;
        nbit_q <= nbit_q + 4'h1;
        if (nbit_q == 4'h0) begin
          // a glitch shorter than half a bit is not a start bit
          if (rxd) act_q <= 1'b0;
        end else if (nbit_q == stop_at) begin
          act_q <= 1'b0;
          valid <= 1'b1;
          ferr  <= !rxd;
          perr  <= line.par_en && (acc_q != line.par_odd); // RULE_08
        end else begin
          acc_q <= acc_q ^ rxd;
          if (nbit_q <= line.width) data[3'(nbit_q - 4'h1)] <= rxd; // RULE_09
        end
      end
    end
  end
endmodule : msps_rx
`default_nettype wire

// *** verilog/msps_tx.sv ***
// character serialiser: start, data, optional parity, one or two stops
`timescale 1ns/1ns
`default_nettype none
module msps_tx
  import msps_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // character format
  input  wire logic [17:0] div,
  input  wire msps_pkg::msps_line_t line,
  // character in
  input  wire logic       start,
  input  wire logic [7:0] data,
  // line out
  output logic            busy,
  output logic            txd
);
  logic [11:0] frame;
  logic [3:0]  len;
  logic [11:0] sh_q;
  logic [3:0]  left_q;
  logic [17:0] bcnt_q;
  logic [7:0]  mask;

  always_comb begin
    mask  = 8'hFF >> (4'h8 - line.width);
    frame = 12'hFFF;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(line.width)) frame[i+1] = data[i]; // RULE_09
    end
    if (line.par_en) frame[line.width+4'h1] = ^(data & mask) ^ line.par_odd; // RULE_08
    len = 4'h2 + line.width + {3'h0, line.par_en} + {3'h0, line.two_stop}; // RULE_10
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_q   <= 12'hFFF;
      left_q <= 4'h0;
      bcnt_q <= 18'h00000;
      busy   <= 1'b0;
      txd    <= 1'b1;
    end else if (!busy) begin
      if (start) begin
        sh_q   <= frame;
        left_q <= len;
        bcnt_q <= div - 18'h00001;
        busy   <= 1'b1;
        txd    <= 1'b0;
      end
    end else if (bcnt_q != 18'h00000) begin
      bcnt_q <= bcnt_q - 18'h00001;
    end else if (left_q == 4'h1) begin
      busy <= 1'b0;
      txd  <= 1'b1;
    end else begin
      sh_q   <= {1'b1, sh_q[11:1]};
      txd    <= sh_q[1];
      left_q <= left_q - 4'h1;
      bcnt_q <= div - 18'h00001;
    end
  end
endmodule : msps_tx
`default_nettype wire
